// [hdl/lane_align_config_octets.sv]
// Overview of operation
// - Override replaces lane-2 coder word with {word_low[7:4], word_high[7:2]}.
// - Force register bit 6 enables the lane-2 override on the low-octet coder.
// - No alignment sequence after reset until software enables it.
// - Enabled sequence sends configuration octets 0 to 13, mode dependent.
// - Octet 0 and octet 1 identifiers are zero.
// - Octet 3 has scramble enable in MSB, lane count minus one in low bits.
// - Octet 4 frame minus one, octet 5 multiframe minus one or override.
// - Octets 6 to 8 carry fixed converter, resolution and sample fields.
// - Octets 9 to 12 zero, octet 13 checksum.
// - Programmed multiframe value used only while its write enable is set.
// - Frame field defaults to one; changing it needs its write enable.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module lane_align_config_octets
    import lane_align_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Avalon-MM register slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Sample stream in
    input wire logic [15:0] sample_data,
    input wire logic sample_valid,
    output logic sample_ready,
    // Lane-2 coder word in
    input wire logic [9:0] coder_lane2_symbol,
    // Lane octets out
    input wire logic tx_ready,
    output logic tx_valid,
    output logic tx_config,
    output logic [7:0] tx_lane1_octet,
    output logic [7:0] tx_lane2_octet,
    output logic [9:0] tx_lane2_symbol
);

    link_cfg_if cfg ();

    logic ack_reg;
    logic req;
    logic wr_go;
    logic [7:0] reg_idx;
    logic [7:0] wdata;
    logic [31:0] readdata_reg;
    logic [7:0] read_mux;

    logic frame_wren_reg;
    logic multi_wren_reg;
    logic scramble_reg;
    logic [7:0] frame_reg;
    logic [4:0] multi_reg;
    logic lane2_force_reg;
    logic [7:0] word_low_reg;
    logic [7:0] word_high_reg;
    logic align_en_reg;

    logic [7:0] frame_eff;
    logic [4:0] multi_eff;
    logic dual_lane;

    link_state_e state_reg;
    link_state_e state_next;
    logic [3:0] index_reg;
    logic half_reg;
    logic adv;

    logic [15:0] buf_data;
    logic buf_valid;
    logic buf_ready;

    logic tx_valid_reg;
    logic tx_config_reg;
    logic [7:0] lane1_reg;
    logic [7:0] lane2_reg;
    logic [9:0] symbol_reg;

    // Bus handshake: one wait cycle per access
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign wr_go = avs_write && ack_reg;
    assign reg_idx = avs_address[9:2];
    assign wdata = avs_writedata[7:0];
    assign avs_readdata = readdata_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            ack_reg <= 1'b0;
        else
            ack_reg <= req && !ack_reg;
    end

    always_comb
    begin
        read_mux = 8'h00;
        unique case (reg_idx)
            IDX_LINK_CTRL: read_mux = {6'h00, multi_wren_reg, frame_wren_reg};
            IDX_SCRAMBLE: read_mux = {scramble_reg, 7'h00};
            IDX_FRAME: read_mux = frame_reg;
            IDX_MULTI: read_mux = {3'h0, multi_reg};
            IDX_FORCE: read_mux = {1'b0, lane2_force_reg, 6'h00};
            IDX_WORD_LOW: read_mux = word_low_reg;
            IDX_WORD_HIGH: read_mux = word_high_reg;
            IDX_ALIGN: read_mux = {4'h0, dual_lane, state_reg == ST_DATA,
                state_reg == ST_CONFIG, align_en_reg};
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            readdata_reg <= 32'h00000000;
        else if (avs_read && !ack_reg)
            readdata_reg <= {24'h000000, read_mux};
    end

    // Link configuration registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            frame_wren_reg <= 1'b0;
            multi_wren_reg <= 1'b0;
            scramble_reg <= 1'b0;
        end
        else if (wr_go && reg_idx == IDX_LINK_CTRL)
        begin
            frame_wren_reg <= wdata[FRAME_WREN_BIT];
            multi_wren_reg <= wdata[MULTI_WREN_BIT];
        end
        else if (wr_go && reg_idx == IDX_SCRAMBLE)
            scramble_reg <= wdata[SCRAMBLE_BIT];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            frame_reg <= FRAME_RESET;
            multi_reg <= MULTI_RESET;
        end
        else
        begin
            if (wr_go && reg_idx == IDX_FRAME && frame_wren_reg)
                frame_reg <= wdata;
            if (wr_go && reg_idx == IDX_MULTI && multi_wren_reg)
                multi_reg <= wdata[4:0];
        end
    end

    // Lane-2 override registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            lane2_force_reg <= 1'b0;
            word_low_reg <= WORD_RESET;
            word_high_reg <= WORD_RESET;
        end
        else if (wr_go)
        begin
            if (reg_idx == IDX_FORCE)
                lane2_force_reg <= wdata[LANE2_FORCE_BIT];
            if (reg_idx == IDX_WORD_LOW)
                word_low_reg <= wdata;
            if (reg_idx == IDX_WORD_HIGH)
                word_high_reg <= wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            align_en_reg <= 1'b0;
        else if (wr_go && reg_idx == IDX_ALIGN)
            align_en_reg <= wdata[ALIGN_EN_BIT];
    end

    // Effective frame and multiframe values
    assign frame_eff = frame_wren_reg ? frame_reg : FRAME_RESET;
    assign dual_lane = (frame_eff == 8'h00);
    assign multi_eff = multi_wren_reg ? multi_reg : (dual_lane ? MULTI_DUAL : MULTI_SINGLE);

    assign cfg.dual_lane = dual_lane;
    assign cfg.scramble = scramble_reg;
    assign cfg.frame_minus1 = frame_eff;
    assign cfg.multi_minus1 = multi_eff;
    assign cfg.index = index_reg;

    config_octet_gen u_octets
    (
        .cfg (cfg)
    );

    pair_buffer
    #(
        .WIDTH (SAMPLE_WIDTH),
        .DEPTH (BUFFER_DEPTH)
    )
    u_buffer
    (
        .clk_sys (clk_sys),
        .rst_b (rst_b),
        .in_data (sample_data),
        .in_valid (sample_valid),
        .in_ready (sample_ready),
        .out_data (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    // Output stage advances when empty or accepted
    assign adv = !tx_valid_reg || tx_ready;
    assign buf_ready = (state_reg == ST_DATA) && adv && (dual_lane || half_reg);

    // Link sequencing
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (align_en_reg)
                    state_next = ST_CONFIG;
            ST_CONFIG:
                if (!align_en_reg)
                    state_next = ST_IDLE;
                else if (adv && index_reg == CONFIG_LAST)
                    state_next = ST_DATA;
            ST_DATA:
                if (!align_en_reg)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            index_reg <= 4'h0;
        else if (state_reg != ST_CONFIG)
            index_reg <= 4'h0;
        else if (adv && index_reg != CONFIG_LAST)
            index_reg <= index_reg + 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            half_reg <= 1'b0;
        else if (state_reg != ST_DATA || dual_lane)
            half_reg <= 1'b0;
        else if (adv && buf_valid)
            half_reg <= !half_reg;
    end

    // Octet output registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            tx_valid_reg <= 1'b0;
            tx_config_reg <= 1'b0;
            lane1_reg <= 8'h00;
            lane2_reg <= 8'h00;
        end
        else if (adv)
        begin
            tx_valid_reg <= 1'b0;
            tx_config_reg <= 1'b0;
            unique case (state_reg)
                ST_CONFIG:
                begin
                    tx_valid_reg <= 1'b1;
                    tx_config_reg <= 1'b1;
                    lane1_reg <= cfg.octet[0];
                    lane2_reg <= dual_lane ? cfg.octet[1] : 8'h00;
                end
                ST_DATA:
                    if (buf_valid)
                    begin
                        tx_valid_reg <= 1'b1;
                        if (dual_lane)
                        begin
                            lane1_reg <= buf_data[15:8];
                            lane2_reg <= buf_data[7:0];
                        end
                        else
                        begin
                            lane1_reg <= half_reg ? buf_data[7:0] : buf_data[15:8];
                            lane2_reg <= 8'h00;
                        end
                    end
                default:
                begin
                    lane1_reg <= lane1_reg;
                    lane2_reg <= lane2_reg;
                end
            endcase
        end
    end

    // Lane-2 symbol after the coder
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            symbol_reg <= 10'h000;
        else if (lane2_force_reg)
            symbol_reg <= {word_low_reg[7:4], word_high_reg[7:2]};
        else
            symbol_reg <= coder_lane2_symbol;
    end

    assign tx_valid = tx_valid_reg;
    assign tx_config = tx_config_reg;
    assign tx_lane1_octet = lane1_reg;
    assign tx_lane2_octet = lane2_reg;
    assign tx_lane2_symbol = symbol_reg;

endmodule

`default_nettype wire

// [hdl/lane_align_pkg.sv]
package lane_align_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_LINK_CTRL = 8'ha1;
    localparam logic [7:0] IDX_SCRAMBLE = 8'ha5;
    localparam logic [7:0] IDX_FRAME = 8'ha6;
    localparam logic [7:0] IDX_MULTI = 8'ha7;
    localparam logic [7:0] IDX_FORCE = 8'hb4;
    localparam logic [7:0] IDX_WORD_LOW = 8'hb8;
    localparam logic [7:0] IDX_WORD_HIGH = 8'hb9;
    localparam logic [7:0] IDX_ALIGN = 8'hc0;

    // Field positions
    localparam int unsigned FRAME_WREN_BIT = 0;
    localparam int unsigned MULTI_WREN_BIT = 1;
    localparam int unsigned SCRAMBLE_BIT = 7;
    localparam int unsigned LANE2_FORCE_BIT = 6;
    localparam int unsigned ALIGN_EN_BIT = 0;
    localparam int unsigned ALIGN_BUSY_BIT = 1;
    localparam int unsigned ALIGN_DONE_BIT = 2;
    localparam int unsigned DUAL_LANE_BIT = 3;

    // Values after reset
    localparam logic [7:0] FRAME_RESET = 8'h01;
    localparam logic [4:0] MULTI_RESET = 5'h00;
    localparam logic [7:0] WORD_RESET = 8'h00;

    // Link configuration field values
    localparam logic [4:0] MULTI_SINGLE = 5'h08;
    localparam logic [4:0] MULTI_DUAL = 5'h10;
    localparam logic [4:0] RESOLUTION = 5'h0d;
    localparam logic [4:0] SAMPLE_BITS = 5'h0f;
    localparam logic [4:0] LANES_SINGLE = 5'h00;
    localparam logic [4:0] LANES_DUAL = 5'h01;
    localparam logic [3:0] CONFIG_LAST = 4'hd;
    localparam int unsigned LANE_COUNT = 2;

    // Data buffer shape
    localparam int unsigned SAMPLE_WIDTH = 16;
    localparam int unsigned BUFFER_DEPTH = 2;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_CONFIG = 3'b010,
        ST_DATA = 3'b100
    } link_state_e;

endpackage

// [hdl/link_cfg_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface link_cfg_if;
    logic dual_lane;
    logic scramble;
    logic [7:0] frame_minus1;
    logic [4:0] multi_minus1;
    logic [3:0] index;
    logic [7:0] octet [2];

    modport gen (input dual_lane, scramble, frame_minus1, multi_minus1, index, output octet);
    modport user (output dual_lane, scramble, frame_minus1, multi_minus1, index, input octet);
endinterface

`default_nettype wire

// [hdl/config_octet_gen.sv]
`timescale 1ns/1ns
`default_nettype none

module config_octet_gen
    import lane_align_pkg::*;
(
    // Configuration in, octets out
    link_cfg_if.gen cfg
);

    genvar lane;
    generate
        for (lane = 0; lane < LANE_COUNT; lane++)
        begin : g_lane
            logic [4:0] lane_id;
            logic [4:0] lanes;
            logic [7:0] checksum;

            // Second lane carries identifier one in dual-lane mode
            assign lane_id = (cfg.dual_lane && lane == 1) ? 5'h01 : 5'h00;
            assign lanes = cfg.dual_lane ? LANES_DUAL : LANES_SINGLE;

            // Sum of field values, zero fields left out
            assign checksum = 8'(lane_id + {7'h00, cfg.scramble} + lanes + cfg.frame_minus1
                + cfg.multi_minus1 + RESOLUTION + SAMPLE_BITS);

            always_comb
            begin
                cfg.octet[lane] = 8'h00;
                unique case (cfg.index)
                    4'h0: cfg.octet[lane] = 8'h00;
                    4'h1: cfg.octet[lane] = 8'h00;
                    4'h2: cfg.octet[lane] = {3'h0, lane_id};
                    4'h3: cfg.octet[lane] = {cfg.scramble, 2'h0, lanes};
                    4'h4: cfg.octet[lane] = cfg.frame_minus1;
                    4'h5: cfg.octet[lane] = {3'h0, cfg.multi_minus1};
                    4'h6: cfg.octet[lane] = 8'h00;
                    4'h7: cfg.octet[lane] = {3'h0, RESOLUTION};
                    4'h8: cfg.octet[lane] = {3'h0, SAMPLE_BITS};
                    4'hd: cfg.octet[lane] = checksum;
                    default: cfg.octet[lane] = 8'h00;
                endcase
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [hdl/pair_buffer.sv]
`timescale 1ns/1ns
`default_nettype none

module pair_buffer
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 2
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule

`default_nettype wire

// [sim/lane_align_chk.sv]
`timescale 1ns/1ns
`default_nettype none

module lane_align_chk
    import lane_align_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register bus
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // Lane side
    input wire logic [9:0] coder_lane2_symbol,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic tx_config,
    input wire logic [7:0] tx_lane1_octet,
    input wire logic [7:0] tx_lane2_octet,
    input wire logic [9:0] tx_lane2_symbol
);
    logic force_reg;
    logic [9:0] word_reg;
    logic [3:0] count_reg;
    logic wr_done;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    assign wr_done = avs_write && !avs_waitrequest;

    // Shadow of the override settings
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            force_reg <= 1'b0;
            word_reg <= 10'h000;
        end
        else if (wr_done && avs_address[9:2] == IDX_FORCE)
            force_reg <= avs_writedata[LANE2_FORCE_BIT];
        else if (wr_done && avs_address[9:2] == IDX_WORD_LOW)
            word_reg[9:6] <= avs_writedata[7:4];
        else if (wr_done && avs_address[9:2] == IDX_WORD_HIGH)
            word_reg[5:0] <= avs_writedata[7:2];
    end

    // Index of the configuration octet on offer
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !tx_config)
            count_reg <= 4'h0;
        else if (tx_valid && tx_ready && count_reg != 4'hf)
            count_reg <= count_reg + 4'h1;
    end

    sequence s_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    AST_WAIT: assert property (($rose(avs_read) || $rose(avs_write)) |-> s_wait)
        else $error("bus access not answered after one wait");
    AST_IDLE: assert property ($rose(rst_b) |-> !tx_valid [*4])
        else $error("octets offered right after reset");
    AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_lane1_octet)
        && $stable(tx_lane2_octet) && $stable(tx_config))
        else $error("stalled octet changed");
    AST_FIRST: assert property ($rose(tx_config) |-> tx_valid && tx_lane1_octet == 8'h00
        && tx_lane2_octet == 8'h00)
        else $error("first configuration octet wrong");
    AST_END: assert property ($fell(tx_config) && tx_valid |-> count_reg == 4'd14)
        else $error("sequence length not fourteen");
    AST_RESERVED: assert property (tx_valid && tx_config && count_reg inside {[4'd9:4'd12]}
        |-> tx_lane1_octet == 8'h00 && tx_lane2_octet == 8'h00)
        else $error("zero octet not zero");
    AST_FORCED: assert property (force_reg && $past(force_reg) && $stable(word_reg)
        |-> tx_lane2_symbol == word_reg)
        else $error("override word not sent");
    AST_PASS: assert property (!force_reg && !$past(force_reg) && $past(rst_b)
        |-> tx_lane2_symbol == $past(coder_lane2_symbol))
        else $error("coder word not passed");
endmodule

`default_nettype wire

// [sim/link_sink.sv]
`timescale 1ns/1ns
`default_nettype none

module link_sink
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Pace select and handshake
    input wire logic slow,
    output logic tx_ready
);
    logic [1:0] pace_reg;

    // Slow pace refuses two cycles in three
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || pace_reg == 2'd2)
            pace_reg <= 2'd0;
        else
            pace_reg <= pace_reg + 2'd1;
    end

    assign tx_ready = rst_b && (!slow || pace_reg == 2'd2);
endmodule

`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, sample_valid, sample_ready;
    logic tx_ready, tx_valid, tx_config, slow;
    logic [9:0] avs_address, coder_lane2_symbol, tx_lane2_symbol;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] sample_data;
    logic [7:0] tx_lane1_octet, tx_lane2_octet;
    int miscompares = 0;
    int tests_run = 0;

    lane_align_config_octets lane_align_config_octets_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
        .coder_lane2_symbol(coder_lane2_symbol), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_config(tx_config), .tx_lane1_octet(tx_lane1_octet), .tx_lane2_octet(tx_lane2_octet),
        .tx_lane2_symbol(tx_lane2_symbol));
    link_sink link_sink_inst (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow), .tx_ready(tx_ready));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic push(input logic [15:0] d);
        @(posedge clk_sys);
        sample_data <= d;
        sample_valid <= 1'b1;
        do @(posedge clk_sys); while (sample_ready !== 1'b1);
        sample_valid <= 1'b0;
    endtask

    task automatic pull(output logic [16:0] o);
        do @(posedge clk_sys); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
        o = {tx_config, tx_lane1_octet, tx_lane2_octet};
    endtask

    function automatic logic [7:0] cfg(input int k, input logic d, ln, s, input logic [4:0] kv);
        logic [7:0] o [14];
        o = '{8'h00, 8'h00, {7'h0, ln}, {s, 6'h0, d}, {7'h0, !d}, {3'h0, kv}, 8'h00,
            8'h0d, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        o[13] = ln + s + d + !d + kv + 8'd28;
        return o[k];
    endfunction

    task automatic cfg_run(input logic d, s, input logic [4:0] kv);
        logic [16:0] o;
        for (int k = 0; k < 14; k++)
        begin
            pull(o);
            check("lane1 octet", {1'b1, cfg(k, d, 1'b0, s, kv)}, o[16:8]);
            check("lane2 octet", d ? cfg(k, d, 1'b1, s, kv) : 8'h00, o[7:0]);
        end
    endtask

    task automatic data(input logic [7:0] e1, e2);
        logic [16:0] o;
        pull(o);
        check("data octets", {1'b0, e1, e2}, o);
    endtask

    task automatic t_regs;
        bus(0, 10'h298, 0);
        check("frame reset", 32'h1, q);
        bus(0, 10'h29c, 0);
        check("multi reset", 32'h0, q);
        bus(1, 10'h298, 0);
        bus(0, 10'h298, 0);
        check("frame locked", 32'h1, q);
        bus(1, 10'h29c, 8'h1f);
        bus(0, 10'h29c, 0);
        check("multi locked", 32'h0, q);
        bus(1, 10'h3fc, 8'hff);
        bus(0, 10'h3fc, 0);
        check("unmapped", 32'h0, q);
        $display("test regs done");
    endtask

    task automatic t_single;
        push(16'h1234);
        push(16'h5678);
        @(posedge clk_sys);
        check("buffer full", 32'h0, sample_ready);
        check("idle", 32'h0, tx_valid);
        slow <= 1'b1;
        bus(1, 10'h294, 8'h80);
        bus(1, 10'h300, 8'h01);
        cfg_run(0, 1, 5'h08);
        data(8'h12, 0);
        data(8'h34, 0);
        data(8'h56, 0);
        data(8'h78, 0);
        check("buffer empty", 32'h1, sample_ready);
        bus(0, 10'h300, 0);
        check("status single", 32'h5, q);
        bus(0, 10'h294, 0);
        check("scramble", 32'h80, q);
        $display("test single done");
    endtask

    task automatic t_dual;
        bus(1, 10'h300, 0);
        bus(1, 10'h294, 0);
        bus(1, 10'h284, 8'h03);
        bus(1, 10'h298, 0);
        bus(1, 10'h29c, 8'h15);
        bus(0, 10'h298, 0);
        check("frame open", 32'h0, q);
        bus(0, 10'h284, 0);
        check("write enables", 32'h3, q);
        push(16'habcd);
        bus(1, 10'h300, 8'h01);
        cfg_run(1, 0, 5'h15);
        data(8'hab, 8'hcd);
        bus(0, 10'h300, 0);
        check("status dual", 32'hd, q);
        bus(1, 10'h300, 0);
        bus(1, 10'h284, 8'h01);
        bus(1, 10'h300, 8'h01);
        cfg_run(1, 0, 5'h10);
        bus(1, 10'h300, 0);
        $display("test dual done");
    endtask

    task automatic t_force;
        bus(1, 10'h2e0, 8'ha0);
        bus(1, 10'h2e4, 8'h5c);
        repeat (2) @(posedge clk_sys);
        check("coder word", 32'h155, tx_lane2_symbol);
        bus(1, 10'h2d0, 8'h40);
        coder_lane2_symbol <= 10'h2aa;
        repeat (2) @(posedge clk_sys);
        check("forced word", 32'h297, tx_lane2_symbol);
        bus(0, 10'h2d0, 0);
        check("force bit", 32'h40, q);
        bus(0, 10'h2e0, 0);
        check("word low", 32'ha0, q);
        bus(0, 10'h2e4, 0);
        check("word high", 32'h5c, q);
        bus(1, 10'h2d0, 0);
        repeat (2) @(posedge clk_sys);
        check("coder back", 32'h2aa, tx_lane2_symbol);
        $display("test force done");
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        miscompares++;
        results();
    end

    initial
    begin
        rst_b <= 1'b0;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 10'h000;
        avs_writedata <= 32'h0;
        sample_data <= 16'h0;
        sample_valid <= 1'b0;
        coder_lane2_symbol <= 10'h155;
        slow <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_single();
        t_dual();
        t_force();
        results();
    end
endmodule

bind lane_align_config_octets lane_align_chk chk_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .coder_lane2_symbol(coder_lane2_symbol), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_config(tx_config), .tx_lane1_octet(tx_lane1_octet),
    .tx_lane2_octet(tx_lane2_octet), .tx_lane2_symbol(tx_lane2_symbol));

`default_nettype wire
